// ===== core/fpe_mode_entry.sv
// mode entry decision and initial-setting receiver on the tool pin
//
// Contract
// - The selectable power-on reset is released before the external reset; an entry under it is not valid.
// - The initial-setting exchange completes no later than 100 ms after external reset release.
// - The tool pin serial link runs only at 115,200 bit/s.
// - Programming mode counts as entered only after the initial exchange has been received.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.svh"

module fpe_mode_entry #(
  parameter logic [`FPE_CNT_W-1:0] HOLD_CYC = `FPE_CNT_W'(`FPE_HOLD_CYC),
  parameter logic [`FPE_CNT_W-1:0] INIT_CYC = `FPE_CNT_W'(`FPE_INIT_CYC)
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          selectable_power_on_reset,
  input  wire logic          ext_reset_n,
  input  wire logic          program_tool_pin,
  output var  fpe_pkg::fpe_status_t status,
  output logic [7:0]         init_byte
);

  localparam logic [`FPE_CNT_W-1:0] SETUP_CYC = `FPE_CNT_W'(`FPE_SETUP_CYC);
  localparam logic [`FPE_BIT_W-1:0] BIT_CYC   = `FPE_BIT_W'(`FPE_BIT_CYC);
  localparam logic [`FPE_BIT_W-1:0] HALF_CYC  = `FPE_BIT_W'(`FPE_HALF_CYC);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic por_s1, por_s2;
  logic ext_s1, ext_s2;
  logic tool_s1, tool_s2, tool_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      por_s1  <= 1'h1;
      por_s2  <= 1'h1;
      ext_s1  <= 1'h0;
      ext_s2  <= 1'h0;
      tool_s1 <= 1'h1;
      tool_s2 <= 1'h1;
      tool_q  <= 1'h1;
    end else begin
      por_s1  <= selectable_power_on_reset;
      por_s2  <= por_s1;
      ext_s1  <= ext_reset_n;
      ext_s2  <= ext_s1;
      tool_s1 <= program_tool_pin;
      tool_s2 <= tool_s1;
      tool_q  <= tool_s2;
    end
  end

  // ----------------------------------------
  // entry sequencer
  // ----------------------------------------
  fpe_pkg::fpe_state_t  state, next_state;
  logic [`FPE_CNT_W-1:0] setup_cnt, next_setup_cnt;
  logic [`FPE_CNT_W-1:0] time_cnt, next_time_cnt;
  fpe_pkg::fpe_status_t next_status;
  logic                  rx_done;

  function automatic logic [`FPE_CNT_W-1:0] sat_inc(input logic [`FPE_CNT_W-1:0] v);
    sat_inc = (v == {`FPE_CNT_W{1'h1}}) ? v : v + `FPE_CNT_W'(1);
  endfunction

  always_comb begin
    next_state     = state;
    next_setup_cnt = setup_cnt;
    next_time_cnt  = time_cnt;
    unique case (state)
      fpe_pkg::S_POR_WAIT: begin
        next_setup_cnt = '0;
        if (!ext_s2) begin
          next_state = fpe_pkg::S_EXT_RESET;
        end else begin
          next_state = fpe_pkg::S_NORMAL;
        end
      end
      fpe_pkg::S_EXT_RESET: begin
        next_setup_cnt = tool_s2 ? '0 : sat_inc(setup_cnt);
        next_time_cnt  = '0;
        if (ext_s2) begin
          if (!tool_s2 && setup_cnt >= SETUP_CYC) begin
            next_state = fpe_pkg::S_HOLD_LOW;
          end else begin
            next_state = fpe_pkg::S_NORMAL;
          end
        end
      end
      fpe_pkg::S_HOLD_LOW: begin
        next_time_cnt = sat_inc(time_cnt);
        if (tool_s2 && time_cnt < HOLD_CYC) begin
          next_state = fpe_pkg::S_FAIL;
        end else if (time_cnt >= HOLD_CYC) begin
          next_state = fpe_pkg::S_WAIT_HIGH;
        end
      end
      fpe_pkg::S_WAIT_HIGH: begin
        next_time_cnt = sat_inc(time_cnt);
        if (time_cnt >= INIT_CYC) begin
          next_state = fpe_pkg::S_FAIL;
        end else if (tool_s2) begin
          next_state = fpe_pkg::S_RX_INIT;
        end
      end
      fpe_pkg::S_RX_INIT: begin
        next_time_cnt = sat_inc(time_cnt);
        if (rx_done) begin
          next_state = fpe_pkg::S_PROG;
        end else if (time_cnt >= INIT_CYC) begin
          next_state = fpe_pkg::S_FAIL;
        end
      end
      fpe_pkg::S_PROG, fpe_pkg::S_NORMAL, fpe_pkg::S_FAIL: begin
        next_state = state;
      end
    endcase
    // power-on reset and external reset override every state
    if (por_s2) begin
      next_state = fpe_pkg::S_POR_WAIT;
    end else if (!ext_s2 && state != fpe_pkg::S_POR_WAIT && state != fpe_pkg::S_EXT_RESET) begin
      next_state     = fpe_pkg::S_EXT_RESET;
      next_setup_cnt = '0;
    end
    next_status.prog_mode   = (next_state == fpe_pkg::S_PROG);
    next_status.normal_run  = (next_state == fpe_pkg::S_NORMAL);
    next_status.entry_error = (next_state == fpe_pkg::S_FAIL);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state     <= fpe_pkg::S_POR_WAIT;
      setup_cnt <= '0;
      time_cnt  <= '0;
      status    <= '0;
    end else begin
      state     <= next_state;
      setup_cnt <= next_setup_cnt;
      time_cnt  <= next_time_cnt;
      status    <= next_status;
    end
  end

  // ----------------------------------------
  // initial-setting receiver, 8n1 on the tool pin
  // ----------------------------------------
  logic                  rx_busy, next_rx_busy;
  logic [`FPE_BIT_W-1:0] bit_timer, next_bit_timer;
  logic [3:0]            bit_idx, next_bit_idx;
  logic [7:0]            shift, next_shift;
  logic                  next_rx_done;
  logic [7:0]            next_init_byte;

  always_comb begin
    next_rx_busy   = rx_busy;
    next_bit_timer = bit_timer;
    next_bit_idx   = bit_idx;
    next_shift     = shift;
    next_rx_done   = 1'h0;
    next_init_byte = init_byte;
    if (state != fpe_pkg::S_RX_INIT) begin
      next_rx_busy = 1'h0;
    end else if (!rx_busy) begin
      if (tool_q && !tool_s2) begin
        next_rx_busy   = 1'h1;
        next_bit_timer = HALF_CYC;
        next_bit_idx   = 4'h0;
      end
    end else if (bit_timer != '0) begin
      next_bit_timer = bit_timer - `FPE_BIT_W'(1);
    end else begin
      next_bit_timer = BIT_CYC - `FPE_BIT_W'(1);
      next_bit_idx   = bit_idx + 4'h1;
      if (bit_idx == 4'h0) begin
        next_rx_busy = !tool_s2;
      end else if (bit_idx == `FPE_STOP_IDX) begin
        next_rx_busy   = 1'h0;
        next_rx_done   = tool_s2;
        next_init_byte = tool_s2 ? shift : init_byte;
      end else begin
        next_shift = {tool_s2, shift[7:1]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_busy   <= 1'h0;
      bit_timer <= '0;
      bit_idx   <= 4'h0;
      shift     <= 8'h00;
      rx_done   <= 1'h0;
      init_byte <= 8'h00;
    end else begin
      rx_busy   <= next_rx_busy;
      bit_timer <= next_bit_timer;
      bit_idx   <= next_bit_idx;
      shift     <= next_shift;
      rx_done   <= next_rx_done;
      init_byte <= next_init_byte;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_por_blocks_entry;
    por_s2 |=> (state == fpe_pkg::S_POR_WAIT) ##1 !status.prog_mode;
  endproperty
  a_por_blocks_entry: assert property (p_por_blocks_entry) else $error("entry under power-on reset");

  property p_init_deadline;
    $rose(status.prog_mode) |-> time_cnt <= INIT_CYC + `FPE_CNT_W'(1);
  endproperty
  a_init_deadline: assert property (p_init_deadline) else $error("programming entry after deadline");

  property p_timeout_fails;
    (state == fpe_pkg::S_RX_INIT && time_cnt >= INIT_CYC && !rx_done && !por_s2 && ext_s2)
      |=> status.entry_error;
  endproperty
  a_timeout_fails: assert property (p_timeout_fails) else $error("timeout not flagged");

  property p_bit_period;
    (rx_busy && bit_timer == '0 && bit_idx != `FPE_STOP_IDX && state == fpe_pkg::S_RX_INIT && tool_s2 == 1'h0
      && bit_idx == 4'h0) |=> (bit_timer == BIT_CYC - `FPE_BIT_W'(1)) ##1 (bit_timer == BIT_CYC - `FPE_BIT_W'(2));
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("bit period wrong");

  property p_prog_after_rx;
    $rose(status.prog_mode) |-> $past(rx_done);
  endproperty
  a_prog_after_rx: assert property (p_prog_after_rx) else $error("program mode without exchange");

  property p_high_pin_normal;
    (state == fpe_pkg::S_EXT_RESET && ext_s2 && tool_s2 && !por_s2)
      |=> (state == fpe_pkg::S_NORMAL) && status.normal_run;
  endproperty
  a_high_pin_normal: assert property (p_high_pin_normal) else $error("high tool pin did not start normal run");

endmodule

`default_nettype wire

// ===== core/fpe_defines.svh
// timing and baud constants for the flash programming mode entry block
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

`define FPE_CLK_HZ      100000000
`define FPE_SETUP_US    10
`define FPE_HOLD_MS     1
`define FPE_INIT_MS     100
`define FPE_BAUD        115200
`define FPE_CNT_W       24
`define FPE_BIT_W       10
// setup time rounds up, hold and init times round down
// clock scaled to kHz first so no product leaves 32-bit arithmetic
`define FPE_SETUP_CYC   ((`FPE_SETUP_US * (`FPE_CLK_HZ / 1000) + 999) / 1000)
`define FPE_HOLD_CYC    (`FPE_HOLD_MS * (`FPE_CLK_HZ / 1000))
`define FPE_INIT_CYC    (`FPE_INIT_MS * (`FPE_CLK_HZ / 1000))
`define FPE_BIT_CYC     (`FPE_CLK_HZ / `FPE_BAUD)
`define FPE_HALF_CYC    (`FPE_BIT_CYC / 2)
`define FPE_STOP_IDX    4'h9

`endif

// ===== core/fpe_pkg.sv
// types of the flash programming mode entry block
package fpe_pkg;

  typedef enum logic [2:0] {
    S_POR_WAIT,
    S_EXT_RESET,
    S_HOLD_LOW,
    S_WAIT_HIGH,
    S_RX_INIT,
    S_PROG,
    S_NORMAL,
    S_FAIL
  } fpe_state_t;

  typedef struct packed {
    logic prog_mode;
    logic normal_run;
    logic entry_error;
  } fpe_status_t;

endpackage

// ===== dv/fpe_prog_model.sv
// programmer model driving external reset and tool pin
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.svh"

module fpe_prog_model (
  input  wire logic clk,
  output logic      ext_reset_n,
  output logic      program_tool_pin
);
  initial begin
    ext_reset_n = 1'h0;
    program_tool_pin = 1'h1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // 8n1 byte, lsb first, one bit time a bit
  task automatic send_byte(input logic [7:0] data);
    program_tool_pin = 1'h0;
    wait_cyc(`FPE_BIT_CYC);
    for (int i = 0; i < 8; i++) begin
      program_tool_pin = data[i];
      wait_cyc(`FPE_BIT_CYC);
    end
    program_tool_pin = 1'h1;
    wait_cyc(`FPE_BIT_CYC);
  endtask

  // setup 0 keeps the tool pin high at release
  task automatic enter(input int setup, input int hold, input logic send, input logic [7:0] data);
    ext_reset_n = 1'h0;
    program_tool_pin = 1'h1;
    wait_cyc(5);
    if (setup > 0) begin
      program_tool_pin = 1'h0;
      wait_cyc(setup);
    end
    ext_reset_n = 1'h1;
    wait_cyc(hold);
    program_tool_pin = 1'h1;
    wait_cyc(100);
    if (send) begin
      send_byte(data);
    end
  endtask
endmodule

`default_nettype wire

// ===== dv/fpe_mode_entry_tb_top.sv
// testbench for the flash programming mode entry block
`timescale 1ns/1ps
`default_nettype none

module fpe_mode_entry_tb_top;
  logic                 clk;
  logic                 nrst;
  logic                 por;
  logic                 ext_reset_n;
  logic                 tool;
  fpe_pkg::fpe_status_t status;
  logic [7:0]           init_byte;
  int                   failures;
  int                   checked;

  fpe_prog_model u_fpe_prog_model (
    .clk              (clk),
    .ext_reset_n      (ext_reset_n),
    .program_tool_pin (tool)
  );

  fpe_mode_entry #(
    .HOLD_CYC (24'h000032),
    .INIT_CYC (24'h004e20)
  ) u_fpe_mode_entry (
    .clk                       (clk),
    .nrst                      (nrst),
    .selectable_power_on_reset (por),
    .ext_reset_n               (ext_reset_n),
    .program_tool_pin          (tool),
    .status                    (status),
    .init_byte                 (init_byte)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // waits for a nonzero status, then compares it
  task automatic expect_status(input logic [2:0] exp);
    int n;
    n = 0;
    while (status === 3'h0 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    checked++;
    if (n >= 30000 || status !== exp) begin
      failures++;
      $display("mismatch at %0t: status %b expected %b", $time, status, exp);
      if (n >= 30000) finish_test();
    end
  endtask

  task automatic t_prog_entry();
    u_fpe_prog_model.enter(1100, 60, 1'b1, 8'ha5);
    expect_status(3'h4);
    checked++;
    if (init_byte !== 8'ha5) begin
      failures++;
      $display("mismatch at %0t: init byte %h", $time, init_byte);
    end
  endtask

  task automatic t_por_held();
    por = 1'h1;
    u_fpe_prog_model.enter(1100, 60, 1'h0, 8'h00);
    checked++;
    if (status !== 3'h0) begin
      failures++;
      $display("mismatch at %0t: entry under power-on reset", $time);
    end
    por = 1'b0;
    expect_status(3'h2);
  endtask

  initial begin
    failures = 0;
    checked = 0;
    nrst = 1'h0;
    por = 1'h1;
    repeat (6) @(negedge clk);
    nrst = 1'h1;
    repeat (3) @(negedge clk);
    por = 1'h0;
    repeat (3) @(negedge clk);
    t_prog_entry();
    u_fpe_prog_model.enter(0, 60, 1'h0, 8'h00);
    expect_status(3'h2);
    u_fpe_prog_model.enter(500, 60, 1'h0, 8'h00);
    expect_status(3'h2);
    u_fpe_prog_model.enter(1100, 10, 1'h0, 8'h00);
    expect_status(3'h1);
    u_fpe_prog_model.enter(1100, 60, 1'h0, 8'h00);
    expect_status(3'h1);
    u_fpe_prog_model.enter(1100, 21000, 1'h0, 8'h00);
    expect_status(3'h1);
    t_por_held();
    t_prog_entry();
    finish_test();
  end
endmodule

`default_nettype wire
